/* core/dtc_pkg.sv */
// Purpose: shared constants and types of the dual timer control block
// Assumes: 8-bit register port, one clock, synchronous active-low reset
// Notes: offsets are register addresses on the plain register port
package dtc_pkg;
   // register addresses
   localparam logic [7:0] DTC_ADDR_CONTROL = 8'h88;
   localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
   localparam logic [7:0] DTC_ADDR_A_CNT_LO = 8'h8a;
   localparam logic [7:0] DTC_ADDR_B_CNT_LO = 8'h8b;
   localparam logic [7:0] DTC_ADDR_A_CNT_HI = 8'h8c;
   localparam logic [7:0] DTC_ADDR_B_CNT_HI = 8'h8d;
   localparam logic [7:0] DTC_ADDR_EXTRA = 8'h91;
   localparam logic [7:0] DTC_ADDR_A_RL_LO = 8'hf2;
   localparam logic [7:0] DTC_ADDR_B_RL_LO = 8'hf3;
   localparam logic [7:0] DTC_ADDR_A_RL_HI = 8'hf4;
   localparam logic [7:0] DTC_ADDR_B_RL_HI = 8'hf5;
   localparam logic [7:0] DTC_ADDR_IRQ_STATUS = 8'he0;
   localparam logic [7:0] DTC_ADDR_IRQ_MASK = 8'he1;
   // reset values
   localparam logic [7:0] DTC_RST_CONTROL = 8'h00;
   localparam logic [7:0] DTC_RST_MODE = 8'h00;
   localparam logic [7:0] DTC_RST_EXTRA = 8'h24;
   localparam logic [7:0] DTC_RST_BYTE = 8'h00;
   localparam logic [3:0] DTC_RST_IRQ = 4'h0;
   localparam logic [7:0] DTC_BYTE_ONES = 8'hff;
   localparam logic [15:0] DTC_WORD_ONES = 16'hffff;
   // mode field encodings
   localparam logic [1:0] DTC_MODE_VARIABLE = 2'h0;
   localparam logic [1:0] DTC_MODE_SIXTEEN = 2'h1;
   localparam logic [1:0] DTC_MODE_EIGHT_RELOAD = 2'h2;
   localparam logic [1:0] DTC_MODE_SPLIT_STOP = 2'h3;
   // interrupt status bit positions
   localparam int DTC_IRQ_TF_A = 0;
   localparam int DTC_IRQ_TF_B = 1;
   localparam int DTC_IRQ_EXT_A = 2;
   localparam int DTC_IRQ_EXT_B = 3;

   typedef struct packed {
      logic timer_b_overflow_flag;
      logic timer_b_run;
      logic timer_a_overflow_flag;
      logic timer_a_run;
      logic ext_irq_b_edge_flag;
      logic ext_irq_b_type;
      logic ext_irq_a_edge_flag;
      logic ext_irq_a_type;
   } dtc_control_t;

   typedef struct packed {
      logic gate_enable;
      logic counter_select;
      logic [1:0] mode;
   } dtc_mode_half_t;

   typedef struct packed {
      dtc_mode_half_t b;
      dtc_mode_half_t a;
   } dtc_mode_t;

   typedef struct packed {
      logic pwm_b_enable;
      logic pwm_a_enable;
      logic [2:0] timer_b_width_field;
      logic [2:0] timer_a_width_field;
   } dtc_extra_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtc_bus_req_t;

   typedef struct packed {
      logic ext_irq_a_pin;
      logic ext_irq_b_pin;
      logic timer_a_count_pin;
      logic timer_b_count_pin;
   } dtc_pins_t;

   typedef struct packed {
      logic timer_a;
      logic timer_b;
      logic ext_a;
      logic ext_b;
   } dtc_ack_t;

   typedef struct packed {
      dtc_control_t control;
      dtc_mode_t mode;
      dtc_extra_t extra;
      logic [7:0] a_rl_lo;
      logic [7:0] b_rl_lo;
      logic [7:0] a_rl_hi;
      logic [7:0] b_rl_hi;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic irq;
      logic [7:0] rdata;
   } dtc_state_t;

   // mask of the active low-byte bits for a width field of 0..7
   function automatic logic [7:0] dtc_low_mask(input logic [2:0] width);
      dtc_low_mask = DTC_BYTE_ONES >> (3'd7 - width);
   endfunction

   // write strobe aimed at one register
   function automatic logic dtc_wr_hit(input dtc_bus_req_t req, input logic [7:0] addr);
      dtc_wr_hit = req.wr && (req.addr == addr);
   endfunction
endpackage

/* core/dtc_fall_det.sv */
// Purpose: one-to-zero transition detector for a pin sampled each clock
// Assumes: pin is synchronous to sys_clk
// Notes: fall pulses in the cycle the low sample is seen after a high one
`timescale 1ns/100ps
module dtc_fall_det (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic fall
);
   typedef struct packed {
      logic prev;
   } dtc_fall_state_t;

   dtc_fall_state_t st_q;
   dtc_fall_state_t st_d;

   // remember last sample
   always_comb begin
      st_d = st_q;
      st_d.prev = pin;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // high then low
   assign fall = st_q.prev & ~pin;
endmodule

/* core/dtc_timer_core.sv */
// Purpose: count registers and count arithmetic of one timer
// Assumes: tick already folds in run, gate, source select and halt
// Notes: a software write to a count byte wins over counting that cycle
`timescale 1ns/100ps
module dtc_timer_core (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic tick,
   input wire logic [1:0] mode,
   input wire logic [2:0] width,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic [7:0] wdata,
   input wire logic [15:0] reload,
   output logic [15:0] count,
   output logic overflow
);
   import dtc_pkg::*;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } dtc_count_t;

   dtc_count_t st_q;
   dtc_count_t st_d;
   logic [7:0] low_mask;
   logic low_full;
   logic ovf;

   // next count and overflow for the selected mode
   always_comb begin
      st_d = st_q;
      low_mask = dtc_low_mask(width);
      low_full = (st_q.lo & low_mask) == low_mask;
      ovf = 1'b0;
      if (tick) begin
         unique case (mode)
            DTC_MODE_VARIABLE: begin
               // width+1 low bits then all of hi; upper low bits kept
               st_d.lo = (st_q.lo & ~low_mask) | (8'(st_q.lo + 8'h01) & low_mask);
               if (low_full) begin
                  st_d.hi = 8'(st_q.hi + 8'h01);
               end
               ovf = low_full && (st_q.hi == DTC_BYTE_ONES);
            end
            DTC_MODE_SIXTEEN: begin
               ovf = {st_q.hi, st_q.lo} == DTC_WORD_ONES;
               {st_d.hi, st_d.lo} = ovf ? reload : 16'({st_q.hi, st_q.lo} + 16'h0001);
            end
            DTC_MODE_EIGHT_RELOAD: begin
               ovf = st_q.lo == DTC_BYTE_ONES;
               st_d.lo = ovf ? st_q.hi : 8'(st_q.lo + 8'h01);
            end
            DTC_MODE_SPLIT_STOP: begin
               // low byte as a free 8-bit counter
               ovf = st_q.lo == DTC_BYTE_ONES;
               st_d.lo = 8'(st_q.lo + 8'h01);
            end
         endcase
      end
      if (wr_low) begin
         st_d.lo = wdata;
      end
      if (wr_high) begin
         st_d.hi = wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count = {st_q.hi, st_q.lo};
   assign overflow = ovf;
endmodule

/* core/dtc_top.sv */
// Purpose: control, mode and data registers of two timer/counters
// Assumes: pins synchronous to sys_clk; core acks are one-cycle pulses
// Notes: read data stand in the cycle after the read strobe only
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
// Contract
// - each overflow sets that timer's overflow flag, and the vector acknowledge clears it.
// - a timer counts only while its run bit, written only by software, is one.
// - a qualifying edge on an external interrupt pin sets its edge flag, cleared once processed.
// - the type bit picks falling-edge triggering when set and low-level when clear.
// - with gate set, a timer runs only while its interrupt pin is high and run is set.
// - with gate clear, a timer runs whenever run is set, whatever the pin; timer b still stays halted in mode 3.
// - mode 2 counts the low byte and reloads it from the high byte on overflow.
// - control and mode registers reset to zero, mode 0 with both timers stopped.
// - reload bytes are plain storage when the mode does not reload from them.
// - the four reload bytes sit at consecutive addresses, low bytes first.
// - in mode 0 the low byte has width field plus one active bits, width resetting to four.
// - mode 1 counts all 16 bits and on ffff reloads from the reload pair and sets the flag.
// - counter operation steps on a one-to-zero transition of the count pin.
module dtc_top (
   input wire logic sys_clk,
   input wire logic rst_b,
   input dtc_pkg::dtc_bus_req_t bus_req,
   input dtc_pkg::dtc_pins_t pins,
   input dtc_pkg::dtc_ack_t ack,
   output logic [7:0] rd_data,
   output logic irq,
   output logic timer_a_overflow_flag,
   output logic timer_b_overflow_flag,
   output logic ext_irq_a_edge_flag,
   output logic ext_irq_b_edge_flag
);
   import dtc_pkg::*;

   dtc_state_t st_q;
   dtc_state_t st_d;
   logic fall_ext_a;
   logic fall_ext_b;
   logic fall_cnt_a;
   logic fall_cnt_b;
   logic en_a;
   logic en_b;
   logic tick_a;
   logic tick_b;
   logic ovf_a;
   logic ovf_b;
   logic [15:0] cnt_a;
   logic [15:0] cnt_b;
   logic wr_ctl;
   logic [3:0] events;

   // falling-edge detectors on the four pins
   dtc_fall_det u_fall_ext_a (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin(pins.ext_irq_a_pin),
      .fall(fall_ext_a)
   );
   dtc_fall_det u_fall_ext_b (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin(pins.ext_irq_b_pin),
      .fall(fall_ext_b)
   );
   dtc_fall_det u_fall_cnt_a (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin(pins.timer_a_count_pin),
      .fall(fall_cnt_a)
   );
   dtc_fall_det u_fall_cnt_b (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin(pins.timer_b_count_pin),
      .fall(fall_cnt_b)
   );

   // enables and count ticks
   always_comb begin
      en_a = st_q.control.timer_a_run && (!st_q.mode.a.gate_enable || pins.ext_irq_a_pin);
      en_b = st_q.control.timer_b_run && (!st_q.mode.b.gate_enable || pins.ext_irq_b_pin);
      tick_a = en_a && (st_q.mode.a.counter_select ? fall_cnt_a : 1'b1);
      tick_b = en_b && (st_q.mode.b.counter_select ? fall_cnt_b : 1'b1)
         && (st_q.mode.b.mode != DTC_MODE_SPLIT_STOP);
   end

   // timer a counting, mode 1 reload from its pair
   dtc_timer_core u_timer_a (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tick(tick_a),
      .mode(st_q.mode.a.mode),
      .width(st_q.extra.timer_a_width_field),
      .wr_low(dtc_wr_hit(bus_req, DTC_ADDR_A_CNT_LO)),
      .wr_high(dtc_wr_hit(bus_req, DTC_ADDR_A_CNT_HI)),
      .wdata(bus_req.wdata),
      .reload({st_q.a_rl_hi, st_q.a_rl_lo}),
      .count(cnt_a),
      .overflow(ovf_a)
   );

   // timer b counting
   dtc_timer_core u_timer_b (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tick(tick_b),
      .mode(st_q.mode.b.mode),
      .width(st_q.extra.timer_b_width_field),
      .wr_low(dtc_wr_hit(bus_req, DTC_ADDR_B_CNT_LO)),
      .wr_high(dtc_wr_hit(bus_req, DTC_ADDR_B_CNT_HI)),
      .wdata(bus_req.wdata),
      .reload({st_q.b_rl_hi, st_q.b_rl_lo}),
      .count(cnt_b),
      .overflow(ovf_b)
   );

   // register file, flags, interrupt and read data
   always_comb begin
      st_d = st_q;
      wr_ctl = dtc_wr_hit(bus_req, DTC_ADDR_CONTROL);
      // software owns run and type bits
      if (wr_ctl) begin
         st_d.control = dtc_control_t'(bus_req.wdata);
      end
      // overflow flags: set beats both clears
      st_d.control.timer_a_overflow_flag = ovf_a
         || (wr_ctl ? bus_req.wdata[5] : (st_q.control.timer_a_overflow_flag && !ack.timer_a));
      st_d.control.timer_b_overflow_flag = ovf_b
         || (wr_ctl ? bus_req.wdata[7] : (st_q.control.timer_b_overflow_flag && !ack.timer_b));
      // edge mode latches the fall, level mode follows the low pin
      if (st_d.control.ext_irq_a_type) begin
         st_d.control.ext_irq_a_edge_flag = fall_ext_a
            || (wr_ctl ? bus_req.wdata[1] : (st_q.control.ext_irq_a_edge_flag && !ack.ext_a));
      end else begin
         st_d.control.ext_irq_a_edge_flag = !pins.ext_irq_a_pin;
      end
      if (st_d.control.ext_irq_b_type) begin
         st_d.control.ext_irq_b_edge_flag = fall_ext_b
            || (wr_ctl ? bus_req.wdata[3] : (st_q.control.ext_irq_b_edge_flag && !ack.ext_b));
      end else begin
         st_d.control.ext_irq_b_edge_flag = !pins.ext_irq_b_pin;
      end
      if (dtc_wr_hit(bus_req, DTC_ADDR_MODE)) begin
         st_d.mode = dtc_mode_t'(bus_req.wdata);
      end
      if (dtc_wr_hit(bus_req, DTC_ADDR_EXTRA)) begin
         st_d.extra = dtc_extra_t'(bus_req.wdata);
      end
      // reload bytes, plain storage outside mode 1
      if (dtc_wr_hit(bus_req, DTC_ADDR_A_RL_LO)) begin
         st_d.a_rl_lo = bus_req.wdata;
      end
      if (dtc_wr_hit(bus_req, DTC_ADDR_B_RL_LO)) begin
         st_d.b_rl_lo = bus_req.wdata;
      end
      if (dtc_wr_hit(bus_req, DTC_ADDR_A_RL_HI)) begin
         st_d.a_rl_hi = bus_req.wdata;
      end
      if (dtc_wr_hit(bus_req, DTC_ADDR_B_RL_HI)) begin
         st_d.b_rl_hi = bus_req.wdata;
      end
      // sticky status, write one to clear, set wins
      events = '0;
      events[DTC_IRQ_TF_A] = ovf_a;
      events[DTC_IRQ_TF_B] = ovf_b;
      events[DTC_IRQ_EXT_A] = fall_ext_a;
      events[DTC_IRQ_EXT_B] = fall_ext_b;
      if (dtc_wr_hit(bus_req, DTC_ADDR_IRQ_STATUS)) begin
         st_d.irq_status = st_q.irq_status & ~bus_req.wdata[3:0];
      end
      st_d.irq_status = st_d.irq_status | events;
      if (dtc_wr_hit(bus_req, DTC_ADDR_IRQ_MASK)) begin
         st_d.irq_mask = bus_req.wdata[3:0];
      end
      st_d.irq = |(st_q.irq_status & st_q.irq_mask);
      // read data for one cycle, unmapped reads give zero
      st_d.rdata = '0;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            DTC_ADDR_CONTROL: st_d.rdata = st_q.control;
            DTC_ADDR_MODE: st_d.rdata = st_q.mode;
            DTC_ADDR_A_CNT_LO: st_d.rdata = cnt_a[7:0];
            DTC_ADDR_B_CNT_LO: st_d.rdata = cnt_b[7:0];
            DTC_ADDR_A_CNT_HI: st_d.rdata = cnt_a[15:8];
            DTC_ADDR_B_CNT_HI: st_d.rdata = cnt_b[15:8];
            DTC_ADDR_EXTRA: st_d.rdata = st_q.extra;
            DTC_ADDR_A_RL_LO: st_d.rdata = st_q.a_rl_lo;
            DTC_ADDR_B_RL_LO: st_d.rdata = st_q.b_rl_lo;
            DTC_ADDR_A_RL_HI: st_d.rdata = st_q.a_rl_hi;
            DTC_ADDR_B_RL_HI: st_d.rdata = st_q.b_rl_hi;
            DTC_ADDR_IRQ_STATUS: st_d.rdata = {4'h0, st_q.irq_status};
            DTC_ADDR_IRQ_MASK: st_d.rdata = {4'h0, st_q.irq_mask};
            default: st_d.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q.control <= dtc_control_t'(DTC_RST_CONTROL);
         st_q.mode <= dtc_mode_t'(DTC_RST_MODE);
         st_q.extra <= dtc_extra_t'(DTC_RST_EXTRA);
         st_q.a_rl_lo <= DTC_RST_BYTE;
         st_q.b_rl_lo <= DTC_RST_BYTE;
         st_q.a_rl_hi <= DTC_RST_BYTE;
         st_q.b_rl_hi <= DTC_RST_BYTE;
         st_q.irq_status <= DTC_RST_IRQ;
         st_q.irq_mask <= DTC_RST_IRQ;
         st_q.irq <= 1'b0;
         st_q.rdata <= DTC_RST_BYTE;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign rd_data = st_q.rdata;
   assign irq = st_q.irq;
   assign timer_a_overflow_flag = st_q.control.timer_a_overflow_flag;
   assign timer_b_overflow_flag = st_q.control.timer_b_overflow_flag;
   assign ext_irq_a_edge_flag = st_q.control.ext_irq_a_edge_flag;
   assign ext_irq_b_edge_flag = st_q.control.ext_irq_b_edge_flag;

   // checks

   // overflow a raises its flag
   AST_TF_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ovf_a |=> st_q.control.timer_a_overflow_flag)
      else $error("timer a overflow did not set its flag");

   // overflow b raises its flag
   AST_TF_B_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ovf_b |=> st_q.control.timer_b_overflow_flag)
      else $error("timer b overflow did not set its flag");

   // acknowledge b drops the flag
   AST_TF_CLR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ack.timer_b && !ovf_b && !wr_ctl) |=> !st_q.control.timer_b_overflow_flag)
      else $error("timer b flag not cleared by acknowledge");

   // acknowledge a drops the flag
   AST_TF_A_CLR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (ack.timer_a && !ovf_a && !wr_ctl) |=> !st_q.control.timer_a_overflow_flag)
      else $error("timer a flag not cleared by acknowledge");

   // stopped timer a holds its count
   AST_RUN_STOP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!st_q.control.timer_a_run && !bus_req.wr) |=> (cnt_a == $past(cnt_a)))
      else $error("timer a moved while stopped");

   // stopped timer b holds its count
   AST_RUN_STOP_B: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!st_q.control.timer_b_run && !bus_req.wr) |=> (cnt_b == $past(cnt_b)))
      else $error("timer b moved while stopped");

   // falling edge latches flag a
   AST_EDGE_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.control.ext_irq_a_type && fall_ext_a && !wr_ctl) |=> st_q.control.ext_irq_a_edge_flag)
      else $error("edge flag a not set by falling edge");

   // acknowledge clears edge flag a
   AST_EDGE_CLR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.control.ext_irq_a_type && ack.ext_a && !fall_ext_a && !wr_ctl) |=> !st_q.control.ext_irq_a_edge_flag)
      else $error("edge flag a not cleared by acknowledge");

   // level flag b tracks the pin
   AST_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!st_q.control.ext_irq_b_type && !wr_ctl) |=> (st_q.control.ext_irq_b_edge_flag == !$past(pins.ext_irq_b_pin)))
      else $error("level flag b does not follow pin");

   // level flag a tracks the pin
   AST_LEVEL_A: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!st_q.control.ext_irq_a_type && !wr_ctl) |=> (st_q.control.ext_irq_a_edge_flag == !$past(pins.ext_irq_a_pin)))
      else $error("level flag a does not follow pin");

   // gated timer b waits for its pin
   AST_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.mode.b.gate_enable && !pins.ext_irq_b_pin && !bus_req.wr) |=> (cnt_b == $past(cnt_b)))
      else $error("gated timer b counted with pin low");

   // gated timer a waits for its pin
   AST_GATE_A: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.mode.a.gate_enable && !pins.ext_irq_a_pin && !bus_req.wr) |=> (cnt_a == $past(cnt_a)))
      else $error("gated timer a counted with pin low");

   // ungated timer a ticks every clock
   AST_NO_GATE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!st_q.mode.a.gate_enable && st_q.control.timer_a_run && !st_q.mode.a.counter_select) |-> tick_a)
      else $error("ungated running timer a did not tick");

   // clock source ticks whenever enabled
   AST_CLOCK_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (en_a && !st_q.mode.a.counter_select) |-> tick_a)
      else $error("enabled clock-source timer a did not tick");

   // reload bytes change only by a write
   AST_RELOAD_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !bus_req.wr |=> $stable({st_q.a_rl_lo, st_q.b_rl_lo, st_q.a_rl_hi, st_q.b_rl_hi}))
      else $error("reload byte changed without a write");

   // mode 2 reloads low from high
   AST_MODE2: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.mode.a.mode == DTC_MODE_EIGHT_RELOAD && tick_a && cnt_a[7:0] == DTC_BYTE_ONES && !bus_req.wr)
      |=> (cnt_a[7:0] == $past(cnt_a[15:8])) && st_q.control.timer_a_overflow_flag)
      else $error("mode 2 reload wrong");

   // mode 3 freezes timer b
   AST_B_HALT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.mode.b.mode == DTC_MODE_SPLIT_STOP && !bus_req.wr) |=> (cnt_b == $past(cnt_b)))
      else $error("timer b counted in mode 3");

   // reset clears control and mode
   AST_RESET: assert property (@(posedge sys_clk)
      !rst_b |=> (st_q.control == '0 && st_q.mode == '0))
      else $error("control or mode not zero after reset");

   // mode 1 wraps into the reload pair
   AST_MODE1: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.mode.b.mode == DTC_MODE_SIXTEEN && tick_b && cnt_b == DTC_WORD_ONES && !bus_req.wr)
      |=> (cnt_b == {$past(st_q.b_rl_hi), $past(st_q.b_rl_lo)}) && st_q.control.timer_b_overflow_flag)
      else $error("mode 1 reload wrong");

   // pin source needs a pin fall
   AST_PIN_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q.mode.a.counter_select && !fall_cnt_a) |-> !tick_a)
      else $error("counter a stepped without pin fall");

   // unmasked status drives the interrupt
   AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ((st_q.irq_status & st_q.irq_mask) != 4'h0) |=> irq)
      else $error("interrupt output missing");

   // main scenarios reached
   COV_MODE1: cover property (@(posedge sys_clk) disable iff (!rst_b)
      st_q.mode.b.mode == DTC_MODE_SIXTEEN && ovf_b);
   COV_MODE2: cover property (@(posedge sys_clk) disable iff (!rst_b)
      st_q.mode.a.mode == DTC_MODE_EIGHT_RELOAD && ovf_a);
   COV_EDGE: cover property (@(posedge sys_clk) disable iff (!rst_b)
      st_q.control.ext_irq_b_type && fall_ext_b);
   COV_PIN_COUNT: cover property (@(posedge sys_clk) disable iff (!rst_b)
      st_q.mode.b.counter_select && tick_b);
   COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(irq));
endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench of the dual timer control registers
// Assumes: pins are driven synchronously; checked counting is stepped by count pin falls, though timer a counts clocks after mode 8'h50
// Notes: the bench tracks reload bytes with integers, uses fixed expected counts except for the random timer b reload pair, and compares on every read
`timescale 1ns/100ps
module tb_top;
   import dtc_pkg::*;
   logic sys_clk;
   logic rst_b;
   dtc_bus_req_t bus_req;
   dtc_pins_t pins;
   dtc_ack_t ack;
   logic [7:0] rd_data;
   logic irq, tf_a, tf_b, ef_a, ef_b;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int rl[4];
   logic [7:0] d;

   dtc_top dtc_top_i (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .bus_req(bus_req),
      .pins(pins),
      .ack(ack),
      .rd_data(rd_data),
      .irq(irq),
      .timer_a_overflow_flag(tf_a),
      .timer_b_overflow_flag(tf_b),
      .ext_irq_a_edge_flag(ef_a),
      .ext_irq_b_edge_flag(ef_b)
   );

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= v;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   // read strobe, data taken in the following cycle only
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), rd_data, exp);
   endtask

   // one high-to-low-to-high pulse on a count pin
   task automatic pulse(input bit b);
      @(posedge sys_clk);
      if (b) pins.timer_b_count_pin <= 1'b0;
      else pins.timer_a_count_pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
      if (b) pins.timer_b_count_pin <= 1'b1;
      else pins.timer_a_count_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic endt(input string nm);
      $display("test %s done", nm);
   endtask

   initial begin
      rst_b = 1'b0;
      bus_req = '0;
      pins = '1;
      ack = '0;
      void'($urandom(14));
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      // reset values and an unmapped place
      rc(DTC_ADDR_CONTROL, 8'h00);
      rc(DTC_ADDR_MODE, 8'h00);
      rc(DTC_ADDR_EXTRA, 8'h24);
      rc(8'h90, 8'h00);
      endt("reset");
      // reload bytes as plain storage at consecutive addresses
      foreach (rl[i]) begin
         rl[i] = $urandom & 8'hff;
         wr(8'hf2 + 8'(i), 8'(rl[i]));
      end
      foreach (rl[i]) rc(8'hf2 + 8'(i), 8'(rl[i]));
      endt("storage");
      // mode 2 counting pin falls, with interrupt mask
      wr(DTC_ADDR_IRQ_MASK, 8'h01);
      wr(DTC_ADDR_MODE, 8'h06);
      wr(DTC_ADDR_A_CNT_HI, 8'hf0);
      wr(DTC_ADDR_A_CNT_LO, 8'hfe);
      wr(DTC_ADDR_CONTROL, 8'h10);
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'hff);
      pulse(0);
      chk("tf_a", {7'h0, tf_a}, 8'h01);
      chk("irq", {7'h0, irq}, 8'h01);
      rc(DTC_ADDR_A_CNT_LO, 8'hf0);
      @(posedge sys_clk);
      ack.timer_a <= 1'b1;
      @(posedge sys_clk);
      ack.timer_a <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("tf_a", {7'h0, tf_a}, 8'h00);
      wr(DTC_ADDR_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq", {7'h0, irq}, 8'h00);
      endt("reload8");
      // run bit off stops counting
      wr(DTC_ADDR_CONTROL, 8'h00);
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'hf0);
      endt("run");
      // gating by the interrupt pin, level flag follows the pin
      wr(DTC_ADDR_MODE, 8'h0e);
      wr(DTC_ADDR_CONTROL, 8'h10);
      pins.ext_irq_a_pin <= 1'b0;
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'hf0);
      chk("ef_a", {7'h0, ef_a}, 8'h01);
      @(posedge sys_clk);
      pins.ext_irq_a_pin <= 1'b1;
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'hf1);
      chk("ef_a", {7'h0, ef_a}, 8'h00);
      wr(DTC_ADDR_MODE, 8'h06);
      pins.ext_irq_a_pin <= 1'b0;
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'hf2);
      @(posedge sys_clk);
      pins.ext_irq_a_pin <= 1'b1;
      endt("gate");
      // mode 0 with five active low bits
      wr(DTC_ADDR_MODE, 8'h04);
      wr(DTC_ADDR_A_CNT_HI, 8'h00);
      wr(DTC_ADDR_A_CNT_LO, 8'h1f);
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'h00);
      rc(DTC_ADDR_A_CNT_HI, 8'h01);
      endt("mode0");
      // mode 1 wraps from all ones into the reload pair
      wr(DTC_ADDR_CONTROL, 8'h00);
      wr(DTC_ADDR_A_RL_LO, 8'h34);
      wr(DTC_ADDR_A_RL_HI, 8'h12);
      wr(DTC_ADDR_MODE, 8'h05);
      wr(DTC_ADDR_A_CNT_LO, 8'hff);
      wr(DTC_ADDR_A_CNT_HI, 8'hff);
      wr(DTC_ADDR_CONTROL, 8'h10);
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'h34);
      rc(DTC_ADDR_A_CNT_HI, 8'h12);
      chk("tf_a", {7'h0, tf_a}, 8'h01);
      endt("mode1");
      // falling-edge type: sticky flag cleared by acknowledge
      wr(DTC_ADDR_CONTROL, 8'h01);
      pins.ext_irq_a_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
      pins.ext_irq_a_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("ef_a", {7'h0, ef_a}, 8'h01);
      @(posedge sys_clk);
      ack.ext_a <= 1'b1;
      @(posedge sys_clk);
      ack.ext_a <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("ef_a", {7'h0, ef_a}, 8'h00);
      endt("edge");
      // timer b halted in mode 3, counts in mode 1
      wr(DTC_ADDR_MODE, 8'h77);
      wr(DTC_ADDR_CONTROL, 8'h50);
      pulse(1);
      rc(DTC_ADDR_B_CNT_LO, 8'h00);
      pulse(0);
      rc(DTC_ADDR_A_CNT_LO, 8'h35);
      wr(DTC_ADDR_MODE, 8'h50);
      pulse(1);
      rc(DTC_ADDR_B_CNT_LO, 8'h01);
      // timer b wraps into its random reload pair, level flag b follows its pin
      wr(DTC_ADDR_B_CNT_LO, 8'hff);
      wr(DTC_ADDR_B_CNT_HI, 8'hff);
      pins.ext_irq_b_pin <= 1'b0;
      pulse(1);
      rc(DTC_ADDR_B_CNT_LO, 8'(rl[1]));
      rc(DTC_ADDR_B_CNT_HI, 8'(rl[3]));
      chk("tf_b", {7'h0, tf_b}, 8'h01);
      chk("ef_b", {7'h0, ef_b}, 8'h01);
      endt("timer_b");
      finish_test();
   end
endmodule
